// >>> logic/zxd_pkg.sv
// Constants shared by the zero-cross event logic.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
`default_nettype none
package zxd_pkg;
   // ***********************************************
   // Register byte offsets
   // ***********************************************
   localparam logic [7:0] ADDR_DET_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_MASK   = 8'h08;
   localparam logic [7:0] ADDR_IRQ_CTRL   = 8'h0C;
   localparam logic [7:0] ADDR_CONFIG     = 8'h10;

   // ***********************************************
   // Detector control register fields
   // ***********************************************
   localparam int CTRL_ENABLE_POS = 7;
   localparam int CTRL_LEVEL_POS  = 5;
   localparam int CTRL_INVERT_POS = 4;
   localparam int CTRL_RISE_POS   = 1;
   localparam int CTRL_FALL_POS   = 0;

   // ***********************************************
   // Interrupt and config register fields
   // ***********************************************
   localparam int STATUS_EVENT_POS = 0;
   localparam int MASK_EVENT_POS   = 0;
   localparam int IRQ_PERIPH_POS   = 0;
   localparam int IRQ_GLOBAL_POS   = 1;
   localparam int CONFIG_PODD_POS  = 0;

   // ***********************************************
   // Reset values
   // ***********************************************
   localparam logic RST_ENABLE = 1'b0;
   localparam logic RST_INVERT = 1'b0;
   localparam logic RST_RISE   = 1'b0;
   localparam logic RST_FALL   = 1'b0;
   localparam logic RST_FLAG   = 1'b0;
   localparam logic RST_MASK   = 1'b0;
   localparam logic RST_PERIPH = 1'b0;
   localparam logic RST_GLOBAL = 1'b0;

   // ***********************************************
   // Bus responses and timing
   // ***********************************************
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam int         SYNC_STAGES = 2;
   localparam logic [1:0] STRAP_WAIT  = 2'h3;
endpackage
`default_nettype wire

// >>> logic/zxd_sync.sv
// Two-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; no multi-bit coherence is implied.
`default_nettype none
module zxd_sync
   import zxd_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,     // System clock
   input  wire logic             rst,     // Sync reset, active high
   input  wire logic [WIDTH-1:0] async_i, // Levels from outside
   output var  logic [WIDTH-1:0] sync_o   // Levels in clock domain
);
   logic [WIDTH-1:0] meta_q;

   // ***********************************************
   // Synchroniser stages
   // ***********************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= '0;
         sync_o <= '0;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule
`default_nettype wire

// >>> logic/zxd_top.sv
// Zero-cross detector event logic with an AXI4-Lite register slave.
// Assumes the analog stage gives a raw sink/source decision level
// and a power-on disable strap, both asynchronous to CLK.
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`default_nettype none
module zxd_top
   import zxd_pkg::*;
(
   input  wire logic        CLK,            // System clock, 250 MHz
   input  wire logic        SYS_RST,        // Sync reset, active high
   input  wire logic        SINK_ACTIVE,    // Raw comparator: 1 = sink
   input  wire logic        PWR_ON_DISABLE, // Power-on disable strap
   output var  logic        CROSS_LEVEL,    // Level to logic cells
   output var  logic        IRQ,            // Interrupt request, level
   input  wire logic [7:0]  S_AXI_AWADDR,   // Write address
   input  wire logic        S_AXI_AWVALID,  // Write address valid
   output var  logic        S_AXI_AWREADY,  // Write address ready
   input  wire logic [31:0] S_AXI_WDATA,    // Write data
   input  wire logic [3:0]  S_AXI_WSTRB,    // Write byte strobes
   input  wire logic        S_AXI_WVALID,   // Write data valid
   output var  logic        S_AXI_WREADY,   // Write data ready
   output var  logic [1:0]  S_AXI_BRESP,    // Write response
   output var  logic        S_AXI_BVALID,   // Write response valid
   input  wire logic        S_AXI_BREADY,   // Write response ready
   input  wire logic [7:0]  S_AXI_ARADDR,   // Read address
   input  wire logic        S_AXI_ARVALID,  // Read address valid
   output var  logic        S_AXI_ARREADY,  // Read address ready
   output var  logic [31:0] S_AXI_RDATA,    // Read data
   output var  logic [1:0]  S_AXI_RRESP,    // Read response
   output var  logic        S_AXI_RVALID,   // Read data valid
   input  wire logic        S_AXI_RREADY    // Read data ready
);
   // ***********************************************
   // Declarations
   // ***********************************************
   logic [1:0]  sync_out;
   logic        sink_s;
   logic        strap_s;
   logic        enable_q;
   logic        invert_q;
   logic        rise_en_q;
   logic        fall_en_q;
   logic        flag_q;
   logic        flag_d;
   logic        mask_q;
   logic        periph_q;
   logic        global_q;
   logic        strap_q;
   logic [1:0]  strap_cnt_q;
   logic        level_q;
   logic        prev_q;
   logic        rise_evt;
   logic        fall_evt;
   logic        invert_evt_q;
   logic        set_evt;
   logic        clr_evt;
   logic        aw_held_q;
   logic        aw_held_d;
   logic        w_held_q;
   logic        w_held_d;
   logic [7:0]  aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        bvalid_d;
   logic        rvalid_d;
   logic        aw_hs;
   logic        w_hs;
   logic        wr_fire;
   logic        rd_fire;
   logic        wr_ctrl;

   // ***********************************************
   // Address decode
   // ***********************************************
   function automatic logic addr_mapped(input logic [7:0] a);
      addr_mapped = (a == ADDR_DET_CTRL) || (a == ADDR_IRQ_STATUS) ||
                    (a == ADDR_IRQ_MASK) || (a == ADDR_IRQ_CTRL) ||
                    (a == ADDR_CONFIG);
   endfunction

   // ***********************************************
   // Input synchronisers
   // ***********************************************
   zxd_sync #(
      .WIDTH (2)
   ) u_sync (
      .clk     (CLK),
      .rst     (SYS_RST),
      .async_i ({PWR_ON_DISABLE, SINK_ACTIVE}),
      .sync_o  (sync_out)
   );

   assign sink_s  = sync_out[0];
   assign strap_s = sync_out[1];

   // ***********************************************
   // Write channel handshakes
   // ***********************************************
   assign aw_hs   = S_AXI_AWVALID & S_AXI_AWREADY;
   assign w_hs    = S_AXI_WVALID & S_AXI_WREADY;
   assign wr_fire = aw_held_q & w_held_q & ~S_AXI_BVALID;
   assign rd_fire = S_AXI_ARVALID & S_AXI_ARREADY;
   assign wr_ctrl = wr_fire & (aw_addr_q == ADDR_DET_CTRL) & w_strb_q[0];

   always_comb begin
      aw_held_d = aw_held_q;
      w_held_d  = w_held_q;
      bvalid_d  = S_AXI_BVALID;
      if (wr_fire) begin
         aw_held_d = 1'b0;
         w_held_d  = 1'b0;
         bvalid_d  = 1'b1;
      end else begin
         if (aw_hs) begin
            aw_held_d = 1'b1;
         end
         if (w_hs) begin
            w_held_d = 1'b1;
         end
         if (S_AXI_BVALID && S_AXI_BREADY) begin
            bvalid_d = 1'b0;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         aw_held_q     <= 1'b0;
         w_held_q      <= 1'b0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY  <= 1'b0;
         S_AXI_BVALID  <= 1'b0;
      end else begin
         aw_held_q     <= aw_held_d;
         w_held_q      <= w_held_d;
         S_AXI_AWREADY <= ~aw_held_d & ~bvalid_d;
         S_AXI_WREADY  <= ~w_held_d & ~bvalid_d;
         S_AXI_BVALID  <= bvalid_d;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
      end else begin
         if (aw_hs) begin
            aw_addr_q <= {S_AXI_AWADDR[7:2], 2'b00};
         end
         if (w_hs) begin
            w_data_q <= S_AXI_WDATA;
            w_strb_q <= S_AXI_WSTRB;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         S_AXI_BRESP <= RESP_OKAY;
      end else if (wr_fire) begin
         S_AXI_BRESP <= addr_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end
   end

   // ***********************************************
   // Read channel
   // ***********************************************
   assign rvalid_d = rd_fire ? 1'b1 :
                     (S_AXI_RREADY ? 1'b0 : S_AXI_RVALID);

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         S_AXI_RVALID  <= 1'b0;
         S_AXI_ARREADY <= 1'b0;
      end else begin
         S_AXI_RVALID  <= rvalid_d;
         S_AXI_ARREADY <= ~rvalid_d;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         S_AXI_RDATA <= 32'h0000_0000;
         S_AXI_RRESP <= RESP_OKAY;
      end else if (rd_fire) begin
         S_AXI_RDATA <= 32'h0000_0000;
         S_AXI_RRESP <= addr_mapped({S_AXI_ARADDR[7:2], 2'b00}) ?
                        RESP_OKAY : RESP_SLVERR;
         unique case ({S_AXI_ARADDR[7:2], 2'b00})
            ADDR_DET_CTRL: begin
               S_AXI_RDATA[CTRL_ENABLE_POS] <= enable_q;
               S_AXI_RDATA[CTRL_LEVEL_POS]  <= level_q;
               S_AXI_RDATA[CTRL_INVERT_POS] <= invert_q;
               S_AXI_RDATA[CTRL_RISE_POS]   <= rise_en_q;
               S_AXI_RDATA[CTRL_FALL_POS]   <= fall_en_q;
            end
            ADDR_IRQ_STATUS: begin
               S_AXI_RDATA[STATUS_EVENT_POS] <= flag_q;
            end
            ADDR_IRQ_MASK: begin
               S_AXI_RDATA[MASK_EVENT_POS] <= mask_q;
            end
            ADDR_IRQ_CTRL: begin
               S_AXI_RDATA[IRQ_PERIPH_POS] <= periph_q;
               S_AXI_RDATA[IRQ_GLOBAL_POS] <= global_q;
            end
            ADDR_CONFIG: begin
               S_AXI_RDATA[CONFIG_PODD_POS] <= strap_q;
            end
            default: begin
               S_AXI_RDATA <= 32'h0000_0000;
            end
         endcase
      end
   end

   // ***********************************************
   // Power-on enable from strap
   // ***********************************************
   // Strap is read only after the synchroniser has settled
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         strap_cnt_q <= 2'h0;
         strap_q     <= 1'b0;
      end else if (strap_cnt_q != STRAP_WAIT) begin
         strap_cnt_q <= strap_cnt_q + 2'h1;
         strap_q     <= strap_s;
      end
   end

   // ***********************************************
   // Detector control register
   // ***********************************************
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         enable_q <= RST_ENABLE;
      end else if (wr_ctrl) begin
         enable_q <= w_data_q[CTRL_ENABLE_POS];
      end else if (strap_cnt_q == (STRAP_WAIT - 2'h1)) begin
         enable_q <= ~strap_s;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         invert_q     <= RST_INVERT;
         rise_en_q    <= RST_RISE;
         fall_en_q    <= RST_FALL;
         invert_evt_q <= 1'b0;
      end else begin
         invert_evt_q <= wr_ctrl &
                         (w_data_q[CTRL_INVERT_POS] != invert_q);
         if (wr_ctrl) begin
            invert_q  <= w_data_q[CTRL_INVERT_POS];
            rise_en_q <= w_data_q[CTRL_RISE_POS];
            fall_en_q <= w_data_q[CTRL_FALL_POS];
         end
      end
   end

   // ***********************************************
   // Interrupt enable registers
   // ***********************************************
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         mask_q   <= RST_MASK;
         periph_q <= RST_PERIPH;
         global_q <= RST_GLOBAL;
      end else if (wr_fire && w_strb_q[0]) begin
         if (aw_addr_q == ADDR_IRQ_MASK) begin
            mask_q <= w_data_q[MASK_EVENT_POS];
         end
         if (aw_addr_q == ADDR_IRQ_CTRL) begin
            periph_q <= w_data_q[IRQ_PERIPH_POS];
            global_q <= w_data_q[IRQ_GLOBAL_POS];
         end
      end
   end

   // ***********************************************
   // Level and edge detection
   // ***********************************************
   // No sleep input gates any of this logic
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         level_q <= 1'b0;
         prev_q  <= 1'b0;
      end else begin
         level_q <= enable_q & (sink_s ^ invert_q);
         prev_q  <= level_q;
      end
   end

   assign rise_evt = level_q & ~prev_q;
   assign fall_evt = ~level_q & prev_q;

   // ***********************************************
   // Event flag
   // ***********************************************
   assign set_evt = (rise_evt & rise_en_q) | (fall_evt & fall_en_q) |
                    invert_evt_q;
   assign clr_evt = rd_fire &
                    ({S_AXI_ARADDR[7:2], 2'b00} == ADDR_IRQ_STATUS);

   always_comb begin
      flag_d = flag_q;
      if (set_evt) begin
         flag_d = 1'b1;
      end else if (clr_evt) begin
         flag_d = 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         flag_q <= RST_FLAG;
      end else begin
         flag_q <= flag_d;
      end
   end

   // ***********************************************
   // Outputs
   // ***********************************************
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         IRQ         <= 1'b0;
         CROSS_LEVEL <= 1'b0;
      end else begin
         IRQ         <= flag_q & mask_q & periph_q & global_q;
         CROSS_LEVEL <= level_q;
      end
   end
endmodule
`default_nettype wire

// >>> verif/zxd_top_properties.sv
// Port assertions for the zero-cross event block.
// Assumes it is bound into zxd_top: one clock, sync active-high reset.
`default_nettype none
module zxd_top_properties
   import zxd_pkg::*;
(
   input wire logic        CLK,           // System clock
   input wire logic        SYS_RST,       // Sync reset
   input wire logic        SINK_ACTIVE,   // Raw decision
   input wire logic        CROSS_LEVEL,   // Adjusted level
   input wire logic        IRQ,           // Interrupt
   input wire logic        S_AXI_AWVALID, // Write address valid
   input wire logic        S_AXI_AWREADY, // Write address ready
   input wire logic        S_AXI_WVALID,  // Write data valid
   input wire logic        S_AXI_WREADY,  // Write data ready
   input wire logic [1:0]  S_AXI_BRESP,   // Write response
   input wire logic        S_AXI_BVALID,  // Write response valid
   input wire logic        S_AXI_BREADY,  // Write response ready
   input wire logic        S_AXI_ARVALID, // Read address valid
   input wire logic        S_AXI_ARREADY, // Read address ready
   input wire logic [31:0] S_AXI_RDATA,   // Read data
   input wire logic [1:0]  S_AXI_RRESP,   // Read response
   input wire logic        S_AXI_RVALID,  // Read valid
   input wire logic        S_AXI_RREADY   // Read ready
);
   timeunit 1ns;
   timeprecision 1ps;
   // ***********************************************
   // Cycles since the bus last answered
   // ***********************************************
   logic [2:0] calm_q;
   always_ff @(posedge CLK) begin
      if (SYS_RST || S_AXI_BVALID || S_AXI_RVALID) begin
         calm_q <= 3'h0;
      end else if (calm_q != 3'h7) begin
         calm_q <= calm_q + 3'h1;
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   // ***********************************************
   // Properties
   // ***********************************************
   a_level_cause: assert property (
      calm_q >= 3'h6 && $changed(CROSS_LEVEL) |->
      $past(SINK_ACTIVE, 4) != $past(SINK_ACTIVE, 5))
      else $error("level moved without an input change");
   a_irq_cause: assert property (
      calm_q == 3'h7 && $rose(IRQ) |->
      $past(SINK_ACTIVE, 5) != $past(SINK_ACTIVE, 6))
      else $error("interrupt rose without an input edge");
   a_irq_kept: assert property (
      calm_q == 3'h7 |-> !$fell(IRQ))
      else $error("interrupt dropped without bus access");
   a_write_answer: assert property (
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
      |-> ##2 S_AXI_BVALID)
      else $error("write response late");
   a_read_answer: assert property (
      S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read data late");
   a_write_block: assert property (
      S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write taken during response");
   a_read_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read taken during response");
   a_bresp_drop: assert property (
      S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
      else $error("write response held after handshake");
   a_rresp_drop: assert property (
      S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
      else $error("read response held after handshake");
   a_error_zero: assert property (
      S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR |-> S_AXI_RDATA == 32'h0)
      else $error("error read returned data");
   c_irq: cover property ($rose(IRQ));
   c_rd_err: cover property (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR);
   c_wr_err: cover property (S_AXI_BVALID && S_AXI_BRESP == RESP_SLVERR);
endmodule

bind zxd_top zxd_top_properties u_props (
   .CLK, .SYS_RST, .SINK_ACTIVE, .CROSS_LEVEL, .IRQ,
   .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
   .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID,
   .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
   .S_AXI_RREADY
);
`default_nettype wire

// >>> verif/zxd_pin_stage.sv
// Behavioural pin stage: sink/source decision and power-on strap.
// Assumes the bench requests decisions synchronously to clk.
`default_nettype none
module zxd_pin_stage (
   input  wire logic clk,   // System clock
   input  wire logic want,  // Requested decision, 1 = sink
   input  wire logic slow,  // Answer after three edges, not one
   input  wire logic pod,   // Requested strap level
   output var  logic sink,  // Decision seen by the detector
   output var  logic strap  // Strap level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] hist_q = 3'h0;
   always_ff @(posedge clk) begin
      hist_q <= {hist_q[1:0], want};
   end
   always_comb begin
      sink  = slow ? hist_q[2] : hist_q[0];
      strap = pod;
   end
endmodule
`default_nettype wire

// >>> verif/zxd_top_test.sv
// Self-checking bench for the zero-cross event block.
// Assumes zxd_top, the pin stage model and the checker are compiled.
`default_nettype none
module zxd_top_test import zxd_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [7:0] ctrl;
      logic from, to, lvl, flg;
   } zxd_row_t;
   // Fields: ctrl, start and end decision, level, event
   zxd_row_t   rows [8] = '{12'h827, 12'h828, 12'h819, 12'h92B,
                            12'h915, 12'h91A, 12'h806, 12'h935};
   logic [7:0] regs [4] = '{ADDR_IRQ_STATUS, ADDR_IRQ_MASK,
                            ADDR_IRQ_CTRL, ADDR_CONFIG};
   logic        clk, rst = 1'b1, want = 1'b0, slow = 1'b0, pod = 1'b0;
   logic        sink, strap, level, irq, awr, wrdy, bv, arr, rv, keep;
   logic        awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
   logic [7:0]  awa = 8'h00, ara = 8'h00;
   logic [31:0] wdt = 32'h0, rdt, dat;
   logic [1:0]  br, rr, rsp;
   int          checks = 0, miscompares = 0;

   zxd_pin_stage stage (.clk(clk), .want(want), .slow(slow), .pod(pod),
                        .sink(sink), .strap(strap));
   zxd_top dut (.CLK(clk), .SYS_RST(rst), .SINK_ACTIVE(sink),
      .PWR_ON_DISABLE(strap), .CROSS_LEVEL(level), .IRQ(irq),
      .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
      .S_AXI_WDATA(wdt), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
      .S_AXI_WREADY(wrdy), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
      .S_AXI_BREADY(brd), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdt), .S_AXI_RRESP(rr),
      .S_AXI_RVALID(rv), .S_AXI_RREADY(rrd));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ***********************************************
   // Bus and comparison tasks
   // ***********************************************
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      awa <= a;
      wdt <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      brd <= 1'b1;
      do begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wrdy) wv <= 1'b0;
      end while (!bv);
      rsp = br;
      brd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic axi_rd(input logic [7:0] a);
      ara <= a;
      arv <= 1'b1;
      rrd <= 1'b1;
      do begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
      end while (!rv);
      dat = rdt;
      rsp = rr;
      rrd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic complete_run();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      complete_run();
   end
   // ***********************************************
   // Sequence
   // ***********************************************
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (10) @(posedge clk);
      axi_rd(ADDR_DET_CTRL);
      chk("ctrl reset", dat, 32'h80);
      chk("rd okay", rsp, RESP_OKAY);
      foreach (regs[i]) begin
         axi_rd(regs[i]);
         chk("reset value", dat, 32'h0);
      end
      axi_rd(8'h14);
      chk("rd resp", rsp, RESP_SLVERR);
      chk("rd data", dat, 32'h0);
      axi_wr(8'h14, 32'hFF);
      chk("wr resp", rsp, RESP_SLVERR);
      axi_wr(ADDR_IRQ_MASK, 32'h1);
      axi_wr(ADDR_IRQ_CTRL, 32'h3);
      foreach (rows[i]) begin
         want <= rows[i].from;
         axi_wr(ADDR_DET_CTRL, {24'h0, rows[i].ctrl});
         repeat (8) @(posedge clk);
         axi_rd(ADDR_IRQ_STATUS);
         want <= rows[i].to;
         repeat (8) @(posedge clk);
         chk("level pin", level, rows[i].lvl);
         chk("irq", irq, rows[i].flg);
         axi_rd(ADDR_DET_CTRL);
         chk("level bit", dat[CTRL_LEVEL_POS], rows[i].lvl);
         axi_rd(ADDR_IRQ_STATUS);
         chk("flag", dat[STATUS_EVENT_POS], rows[i].flg);
      end
      want <= 1'b0;
      axi_wr(ADDR_DET_CTRL, 32'h00);
      repeat (4) @(posedge clk);
      axi_rd(ADDR_IRQ_STATUS);
      axi_wr(ADDR_DET_CTRL, 32'h10);
      repeat (20) @(posedge clk);
      chk("irq held", irq, 1'b1);
      chk("level off", level, 1'b0);
      axi_rd(ADDR_IRQ_STATUS);
      chk("inv flag", dat, 32'h1);
      axi_wr(ADDR_DET_CTRL, 32'h10);
      repeat (4) @(posedge clk);
      axi_rd(ADDR_IRQ_STATUS);
      chk("same inv", dat, 32'h0);
      axi_wr(ADDR_DET_CTRL, 32'h00);
      for (int g = 0; g < 5; g++) begin
         axi_wr(g < 4 ? ADDR_IRQ_CTRL : ADDR_IRQ_MASK, g < 4 ? g : 0);
         repeat (3) @(posedge clk);
         chk("irq gate", irq, g == 3);
      end
      axi_rd(ADDR_IRQ_STATUS);
      axi_wr(ADDR_DET_CTRL, 32'h83);
      for (int d = 0; d < 12; d++) begin
         slow <= d > 5;
         repeat (8) @(posedge clk);
         axi_rd(ADDR_IRQ_STATUS);
         want <= ~want;
         repeat (d) @(posedge clk);
         axi_rd(ADDR_IRQ_STATUS);
         keep = dat[STATUS_EVENT_POS];
         repeat (8) @(posedge clk);
         axi_rd(ADDR_IRQ_STATUS);
         chk("kept edge", keep | dat[STATUS_EVENT_POS], 1'b1);
      end
      // Second reset with the strap set: detector waits for software
      rst <= 1'b1;
      pod <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (10) @(posedge clk);
      chk("irq reset", irq, 1'b0);
      chk("level reset", level, 1'b0);
      axi_rd(ADDR_CONFIG);
      chk("strap seen", dat, 32'h1);
      axi_rd(ADDR_DET_CTRL);
      chk("strap off", dat, 32'h0);
      axi_wr(ADDR_DET_CTRL, 32'h80);
      chk("wr okay", rsp, RESP_OKAY);
      axi_rd(ADDR_DET_CTRL);
      chk("sw enable", dat, 32'h80);
      complete_run();
   end
endmodule
`default_nettype wire
